// [rcps_pkg.sv]
package rcps_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int PD_HOLD_NS = 10000;
  localparam int PD_HOLD_CYC = (PD_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_NS = 2500000;
  localparam int STARTUP_CYC = (STARTUP_NS / 1000) * CLK_MHZ;
  localparam int STBY_WAKE_NS = 15000;
  localparam int STBY_WAKE_CYC = (STBY_WAKE_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // Trim loop figures
  // ---------------------------------------------------------------
  localparam logic [9:0] REF_RELOAD = 10'h3FF;
  localparam logic [9:0] REF_LOW = 10'h0AE;
  localparam logic [9:0] REF_HIGH = 10'h0B0;
  localparam logic [9:0] REF_NOMINAL_COUNTS = 10'h350;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [7:0] TRIM_MIN = 8'h00;
  localparam logic [7:0] TRIM_MAX = 8'hFF;
  localparam logic [7:0] WAKE_RELOAD_MIN = 8'h05;

  // ---------------------------------------------------------------
  // Command codes and argument counts
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_CANCEL = 5'h00,
    CMD_CARD_DETECT = 5'h01,
    CMD_TAG_QUERY_ACK = 5'h04,
    CMD_RECEIVE = 5'h05,
    CMD_TRANSMIT = 5'h06,
    CMD_TRANSCEIVE = 5'h07,
    CMD_NV_BYTE_WRITE = 5'h08,
    CMD_NV_PAGE_WRITE = 5'h09,
    CMD_NV_READ = 5'h0A,
    CMD_NV_REG_COPY = 5'h0C,
    CMD_PROTOCOL_LOAD = 5'h0D,
    CMD_RANDOM_FILL = 5'h1C,
    CMD_SOFT_RESET = 5'h1F
  } rcps_cmd_e;

  localparam logic [6:0] ARGS_NV_BYTE_WRITE = 7'h03;
  localparam logic [6:0] ARGS_NV_PAGE_WRITE = 7'h02;
  localparam logic [6:0] ARGS_NV_READ = 7'h03;
  localparam logic [6:0] ARGS_NV_REG_COPY = 7'h04;
  localparam logic [6:0] ARGS_PROTOCOL_LOAD = 7'h02;
  localparam logic [6:0] ARGS_TRANSMIT = 7'h01;
  localparam logic [1:0] NV_COPY_SECTOR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_ARGS = 3'b001,
    ST_RUN = 3'b010,
    ST_DET_STBY = 3'b011,
    ST_DET_SAMPLE = 3'b100,
    ST_STANDBY = 3'b101,
    ST_WAKING = 3'b110,
    ST_SHUTDOWN = 3'b111
  } rcps_state_e;

  // ---------------------------------------------------------------
  // Grouped carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] i_low;
    logic [7:0] i_high;
    logic [7:0] q_low;
    logic [7:0] q_high;
  } rcps_limits_s;

  typedef struct packed {
    logic [7:0] i_val;
    logic [7:0] q_val;
  } rcps_sample_s;

  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic regulators_on;
    logic outputs_float;
    logic inputs_clamped;
    logic fifo_clear;
    logic regs_reset;
  } rcps_power_s;

endpackage

// [rcps_trim.sv]
`timescale 1ns/1ps
// Slow oscillator trim: measures one oscillator period with the
// reference timer and steps the trim code on the wake-up timer event.
module rcps_trim #(
  parameter int REF_W = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic start_i,
  input wire logic ref_tick_i,
  input wire logic slow_osc_edge_i,
  input wire logic wake_event_i,
  output logic busy_o,
  output logic [7:0] trim_o,
  output logic [REF_W-1:0] ref_count_o
);
  import rcps_pkg::*;

  initial begin
    if (REF_W != 10) begin
      $error("rcps_trim: reference timer must be 10 bits");
    end
  end

  typedef struct packed {
    logic busy;
    logic measuring;
    logic seen_edge;
    logic [1:0] verdict;
    logic [7:0] trim;
    logic [REF_W-1:0] ref_cnt;
  } rcps_trim_s;

  rcps_trim_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (clear_i) begin
      st_next.busy = 1'b0;
      st_next.measuring = 1'b0;
      st_next.verdict = 2'b00;
    end else begin
      if (start_i) begin
        st_next.busy = 1'b1;
        st_next.verdict = 2'b00;
      end
      if (st_next.busy && wake_event_i) begin
        // Apply previous verdict, then start a new measurement
        if (st_reg.verdict == 2'b01 && st_reg.trim != TRIM_MAX) begin
          st_next.trim = st_reg.trim + 8'h01;
        end else if (st_reg.verdict == 2'b10 &&
                     st_reg.trim != TRIM_MIN) begin
          st_next.trim = st_reg.trim - 8'h01;
        end
        st_next.verdict = 2'b00;
        st_next.ref_cnt = REF_RELOAD;
        st_next.measuring = 1'b1;
        st_next.seen_edge = 1'b0;
      end else if (st_reg.measuring) begin
        if (slow_osc_edge_i) begin
          if (!st_reg.seen_edge) begin
            st_next.seen_edge = 1'b1;
          end else begin
            st_next.measuring = 1'b0;
            if (st_reg.ref_cnt < REF_LOW) begin
              st_next.verdict = 2'b01;
            end else if (st_reg.ref_cnt > REF_HIGH) begin
              st_next.verdict = 2'b10;
            end else begin
              st_next.busy = 1'b0;
            end
          end
        end else if (st_reg.seen_edge && ref_tick_i &&
                     st_reg.ref_cnt != '0) begin
          st_next.ref_cnt = st_reg.ref_cnt - 10'h001;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{busy: 1'b0, measuring: 1'b0, seen_edge: 1'b0,
                  verdict: 2'b00, trim: TRIM_RESET, ref_cnt: '0};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign busy_o = st_reg.busy;
  assign trim_o = st_reg.trim;
  assign ref_count_o = st_reg.ref_cnt;
endmodule

// [rcps_detect.sv]
`timescale 1ns/1ps
// Card detection compare: stores samples, checks them against limits.
module rcps_detect (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic capture_i,
  input wire rcps_pkg::rcps_sample_s sample_i,
  input wire rcps_pkg::rcps_limits_s limits_i,
  output rcps_pkg::rcps_sample_s result_o,
  output logic hit_o
);
  import rcps_pkg::*;

  typedef struct packed {
    rcps_sample_s res;
    logic hit;
  } rcps_det_s;

  rcps_det_s st_reg, st_next;

  function automatic logic outside(input logic [7:0] v,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.hit = 1'b0;
    if (clear_i) begin
      st_next.res = '0;
    end else if (capture_i) begin
      st_next.res = sample_i;
      st_next.hit = outside(sample_i.i_val, limits_i.i_low,
                            limits_i.i_high) ||
                    outside(sample_i.q_val, limits_i.q_low,
                            limits_i.q_high);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign result_o = st_reg.res;
  assign hit_o = st_reg.hit;
endmodule

// [rcps_sequencer.sv]
`timescale 1ns/1ps
// Behaviour
// - Wake event during trimming reloads reference timer to 1023
// - Reference counts half-crystal ticks over one period
// - End value below 174 raises trim
// - End value above 176 lowers trim
// - End value 174..176 ends trimming
// - Cancel command aborts trimming
// - Shutdown pin stops, floats, clamps, resets all but the trim code; the reference count is also kept
// - 10 us high resets; low starts 2.5ms startup
// - Standby bit enters standby, state kept
// - Clearing standby bit wakes after 15 us
// - Modem disable bit turns off transmitter, receiver
// - Detection: standby phase, then sample phase
// - Sample outside limits raises card detect flag
// - No auto wake: no standby without card
// - Command waits for its argument bytes
// - New command code abandons running command
// - Decode codes 00h,01h,04h-07h
// - Decode nonvolatile codes 08h,09h,0Ah
// - Decode 0Ch register copy, 0Dh protocol load
// - Decode 1Ch random fill, 1Fh soft reset
module rcps_sequencer #(
  parameter int STARTUP_CYCLES = rcps_pkg::STARTUP_CYC,
  parameter int PD_HOLD_CYCLES = rcps_pkg::PD_HOLD_CYC,
  parameter int WAKE_CYCLES = rcps_pkg::STBY_WAKE_CYC,
  parameter int FIFO_LEVEL_W = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic shutdown_pin_i,
  input wire logic cmd_write_i,
  input wire logic [4:0] cmd_code_i,
  input wire logic standby_request_bit_i,
  input wire logic modem_disable_bit_i,
  input wire logic [FIFO_LEVEL_W-1:0] fifo_level_i,
  input wire logic fifo_full_i,
  input wire logic [7:0] nv_addr_hi_i,
  input wire logic cmd_done_i,
  input wire logic auto_wake_enable_i,
  input wire logic auto_rearm_enable_i,
  input wire logic auto_detect_on_expiry_i,
  input wire logic trim_enable_i,
  input wire logic ref_tick_i,
  input wire logic slow_osc_edge_i,
  input wire logic wake_event_i,
  input wire rcps_pkg::rcps_sample_s sample_i,
  input wire rcps_pkg::rcps_limits_s limits_i,
  input wire logic card_detect_irq_clr_i,
  output rcps_pkg::rcps_power_s power_o,
  output logic [4:0] active_cmd_o,
  output logic cmd_busy_o,
  output logic cmd_go_o,
  output logic cmd_abort_o,
  output logic ready_o,
  output logic in_standby_o,
  output logic card_detect_irq_o,
  output rcps_pkg::rcps_sample_s result_o,
  output logic [7:0] slow_oscillator_trim_o,
  output logic [9:0] ref_count_o,
  output logic trim_busy_o
);
  import rcps_pkg::*;

  initial begin
    if (STARTUP_CYCLES < 1 || PD_HOLD_CYCLES < 1 || WAKE_CYCLES < 1) begin
      $error("rcps_sequencer: cycle counts must be at least one");
    end
    if (FIFO_LEVEL_W < 7) begin
      $error("rcps_sequencer: fifo level too narrow for page write");
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rcps_state_e state;
    rcps_cmd_e cmd;
    logic [21:0] timer;
    logic [21:0] pd_cnt;
    logic irq;
    logic go;
    logic abort;
    logic fifo_clear;
    logic regs_reset;
  } rcps_seq_s;

  rcps_seq_s st_reg, st_next;

  logic trim_start;
  logic trim_clear;
  logic det_capture;
  logic det_clear;
  logic det_hit;

  function automatic logic known_code(input logic [4:0] c);
    case (c)
      CMD_CANCEL, CMD_CARD_DETECT, CMD_TAG_QUERY_ACK, CMD_RECEIVE,
      CMD_TRANSMIT, CMD_TRANSCEIVE, CMD_NV_BYTE_WRITE,
      CMD_NV_PAGE_WRITE, CMD_NV_READ, CMD_NV_REG_COPY,
      CMD_PROTOCOL_LOAD, CMD_RANDOM_FILL, CMD_SOFT_RESET: begin
        known_code = 1'b1;
      end
      default: begin
        known_code = 1'b0;
      end
    endcase
  endfunction

  function automatic logic [6:0] args_needed(input rcps_cmd_e c);
    case (c)
      CMD_TRANSMIT, CMD_TRANSCEIVE: begin
        args_needed = ARGS_TRANSMIT;
      end
      CMD_NV_BYTE_WRITE: begin
        args_needed = ARGS_NV_BYTE_WRITE;
      end
      CMD_NV_PAGE_WRITE: begin
        args_needed = ARGS_NV_PAGE_WRITE;
      end
      CMD_NV_READ: begin
        args_needed = ARGS_NV_READ;
      end
      CMD_NV_REG_COPY: begin
        args_needed = ARGS_NV_REG_COPY;
      end
      CMD_PROTOCOL_LOAD: begin
        args_needed = ARGS_PROTOCOL_LOAD;
      end
      default: begin
        args_needed = 7'h00;
      end
    endcase
  endfunction

  logic shutdown_held;
  assign shutdown_held = (st_reg.pd_cnt >= 22'(PD_HOLD_CYCLES - 1));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.go = 1'b0;
    st_next.abort = 1'b0;
    st_next.fifo_clear = 1'b0;
    st_next.regs_reset = 1'b0;
    trim_start = 1'b0;
    trim_clear = 1'b0;
    det_capture = 1'b0;
    det_clear = 1'b0;
    if (shutdown_pin_i) begin
      if (!shutdown_held) begin
        st_next.pd_cnt = st_reg.pd_cnt + 22'h000001;
      end else begin
        // Held long enough: internal reset except the trim code and the reference count
        st_next.state = ST_SHUTDOWN;
        st_next.cmd = CMD_CANCEL;
        st_next.irq = 1'b0;
        st_next.fifo_clear = 1'b1;
        st_next.regs_reset = 1'b1;
        st_next.timer = 22'(STARTUP_CYCLES);
        trim_clear = 1'b1;
        det_clear = 1'b1;
      end
    end else begin
      st_next.pd_cnt = '0;
      if (card_detect_irq_clr_i) begin
        st_next.irq = 1'b0;
      end
      if (det_hit) begin
        st_next.irq = 1'b1;
      end
      case (st_reg.state)
        ST_SHUTDOWN, ST_WAKING: begin
          // Start-up sequence after pin release or standby exit
          if (st_reg.timer != '0) begin
            st_next.timer = st_reg.timer - 22'h000001;
          end else begin
            st_next.state = ST_IDLE;
          end
        end
        ST_STANDBY: begin
          if (!standby_request_bit_i) begin
            st_next.state = ST_WAKING;
            st_next.timer = 22'(WAKE_CYCLES);
          end
        end
        default: begin
          if (standby_request_bit_i &&
              st_reg.state != ST_DET_STBY) begin
            st_next.state = ST_STANDBY;
          end else if (cmd_write_i) begin
            // Any new code abandons the running one
            if (st_reg.state != ST_IDLE) begin
              st_next.abort = 1'b1;
            end
            trim_clear = 1'b1;
            if (known_code(cmd_code_i)) begin
              st_next.cmd = rcps_cmd_e'(cmd_code_i);
            end else begin
              st_next.cmd = CMD_CANCEL;
            end
            if (!known_code(cmd_code_i) || cmd_code_i == CMD_CANCEL) begin
              st_next.state = ST_IDLE;
            end else if (cmd_code_i == CMD_CARD_DETECT) begin
              st_next.state = ST_DET_STBY;
              st_next.go = 1'b1;
              trim_start = trim_enable_i;
              trim_clear = !trim_enable_i;
            end else if (cmd_code_i == CMD_SOFT_RESET) begin
              st_next.state = ST_IDLE;
              st_next.regs_reset = 1'b1;
            end else begin
              st_next.state = ST_WAIT_ARGS;
            end
          end else begin
            case (st_reg.state)
              ST_WAIT_ARGS: begin
                if (7'(fifo_level_i) >= args_needed(st_reg.cmd) ||
                    fifo_level_i > FIFO_LEVEL_W'(args_needed(st_reg.cmd))) begin
                  if (st_reg.cmd == CMD_NV_REG_COPY &&
                      nv_addr_hi_i[1:0] != NV_COPY_SECTOR) begin
                    st_next.state = ST_IDLE;
                    st_next.abort = 1'b1;
                  end else begin
                    st_next.state = ST_RUN;
                    st_next.go = 1'b1;
                  end
                end
              end
              ST_RUN: begin
                if ((st_reg.cmd == CMD_RANDOM_FILL && fifo_full_i) ||
                    cmd_done_i) begin
                  st_next.state = ST_IDLE;
                  st_next.cmd = CMD_CANCEL;
                end
              end
              ST_DET_STBY: begin
                if (wake_event_i) begin
                  st_next.state = ST_DET_SAMPLE;
                end
              end
              ST_DET_SAMPLE: begin
                det_capture = 1'b1;
                if (auto_wake_enable_i && auto_rearm_enable_i) begin
                  st_next.state = ST_DET_STBY;
                end else begin
                  st_next.state = ST_IDLE;
                  st_next.cmd = CMD_CANCEL;
                end
              end
              default: begin
                if (trim_enable_i && auto_detect_on_expiry_i &&
                    wake_event_i && !trim_busy_o) begin
                  trim_start = 1'b1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{state: ST_SHUTDOWN, cmd: CMD_CANCEL, timer: '0,
                  pd_cnt: '0, irq: 1'b0, go: 1'b0, abort: 1'b0,
                  fifo_clear: 1'b0, regs_reset: 1'b0};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  rcps_trim #(
    .REF_W(10)
  ) u_trim (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(trim_clear),
    .start_i(trim_start),
    .ref_tick_i(ref_tick_i),
    .slow_osc_edge_i(slow_osc_edge_i),
    .wake_event_i(wake_event_i),
    .busy_o(trim_busy_o),
    .trim_o(slow_oscillator_trim_o),
    .ref_count_o(ref_count_o)
  );

  rcps_detect u_detect (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(det_clear),
    .capture_i(det_capture),
    .sample_i(sample_i),
    .limits_i(limits_i),
    .result_o(result_o),
    .hit_o(det_hit)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic modem_on;
  logic powered;
  assign powered = (st_reg.state != ST_SHUTDOWN);
  assign modem_on = powered && !modem_disable_bit_i &&
                    st_reg.state != ST_STANDBY &&
                    st_reg.state != ST_DET_STBY;

  always_comb begin
    power_o.tx_on = modem_on;
    power_o.rx_on = modem_on;
    power_o.regulators_on = powered && st_reg.state != ST_STANDBY;
    power_o.outputs_float = !powered;
    power_o.inputs_clamped = !powered;
    power_o.fifo_clear = st_reg.fifo_clear;
    power_o.regs_reset = st_reg.regs_reset;
  end

  assign active_cmd_o = st_reg.cmd;
  assign cmd_busy_o = (st_reg.state == ST_WAIT_ARGS) ||
                      (st_reg.state == ST_RUN) ||
                      (st_reg.state == ST_DET_STBY) ||
                      (st_reg.state == ST_DET_SAMPLE);
  assign cmd_go_o = st_reg.go;
  assign cmd_abort_o = st_reg.abort;
  assign ready_o = powered && st_reg.state != ST_WAKING &&
                   st_reg.state != ST_STANDBY;
  assign in_standby_o = (st_reg.state == ST_STANDBY) ||
                        (st_reg.state == ST_DET_STBY);
  assign card_detect_irq_o = st_reg.irq;
endmodule

// [rcps_monitor.sv]
`timescale 1ns/1ps
module rcps_monitor
  import rcps_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic shutdown_pin_i,
  input wire logic cmd_write_i,
  input wire logic [4:0] cmd_code_i,
  input wire logic standby_request_bit_i,
  input wire logic modem_disable_bit_i,
  input wire logic wake_event_i,
  input wire rcps_pkg::rcps_limits_s limits_i,
  input wire rcps_pkg::rcps_power_s power_o,
  input wire logic cmd_busy_o,
  input wire logic cmd_go_o,
  input wire logic cmd_abort_o,
  input wire logic ready_o,
  input wire logic in_standby_o,
  input wire logic card_detect_irq_o,
  input wire rcps_pkg::rcps_sample_s result_o,
  input wire logic [7:0] slow_oscillator_trim_o,
  input wire logic [9:0] ref_count_o,
  input wire logic trim_busy_o
);
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_pin_off:
    assert property (power_o.outputs_float |-> power_o.inputs_clamped &&
      !power_o.regulators_on && !ready_o)
    else $error("floating outputs while powered");
  chk_modem_off:
    assert property (modem_disable_bit_i && $past(modem_disable_bit_i)
      |-> !power_o.tx_on && !power_o.rx_on)
    else $error("radio on while modem disabled");
  chk_standby_in:
    assert property (ready_o && standby_request_bit_i && !shutdown_pin_i
      |=> in_standby_o)
    else $error("standby not entered");
  chk_trim_reload:
    assert property (trim_busy_o && wake_event_i |=>
      ref_count_o == REF_RELOAD)
    else $error("reference timer not reloaded");
  chk_trim_step:
    assert property (!shutdown_pin_i && !$past(shutdown_pin_i) &&
      !$stable(slow_oscillator_trim_o) |->
      ($past(wake_event_i) || $past(wake_event_i, 2)) &&
      (slow_oscillator_trim_o - $past(slow_oscillator_trim_o) == 8'h01 ||
      $past(slow_oscillator_trim_o) - slow_oscillator_trim_o == 8'h01))
    else $error("trim moved off a wake event or by more than one");
  chk_detect_go:
    assert property (cmd_write_i && cmd_code_i == 5'h01 && ready_o &&
      !cmd_busy_o |=> cmd_go_o)
    else $error("card detect not launched");
  chk_new_abort:
    assert property (cmd_write_i && cmd_busy_o && ready_o |=> cmd_abort_o)
    else $error("running command not abandoned");
  chk_irq_cause:
    assert property ($rose(card_detect_irq_o) |->
      result_o.i_val < limits_i.i_low || result_o.i_val > limits_i.i_high ||
      result_o.q_val < limits_i.q_low || result_o.q_val > limits_i.q_high)
    else $error("card detect flag with samples inside limits");
endmodule

bind rcps_sequencer rcps_monitor mon_u (.*);

// [rcps_osc_model.sv]
`timescale 1ns/1ps
module rcps_osc_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] period_i,
  input wire logic wake_go_i,
  output logic ref_tick_o,
  output logic slow_osc_edge_o,
  output logic wake_event_o
);
  logic [9:0] phase_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= 10'h000;
      ref_tick_o <= 1'b0;
      slow_osc_edge_o <= 1'b0;
      wake_event_o <= 1'b0;
    end else begin
      ref_tick_o <= 1'b1;
      slow_osc_edge_o <= (phase_reg == 10'h000);
      phase_reg <= (phase_reg >= period_i - 10'h001) ? 10'h000 :
        phase_reg + 10'h001;
      // Caller spaces wakes wider than a full trim cycle only in t_trim
      wake_event_o <= wake_go_i;
    end
  end
endmodule

// [rcps_sequencer_tb.sv]
`timescale 1ns/1ps
module rcps_sequencer_tb;
  import rcps_pkg::*;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic shutdown_pin_i = 1'b0, cmd_write_i = 1'b0, cmd_done_i = 1'b0;
  logic standby_request_bit_i = 1'b0, modem_disable_bit_i = 1'b0;
  logic fifo_full_i = 1'b0, auto_wake_enable_i = 1'b0, trim_enable_i = 1'b0;
  logic auto_rearm_enable_i = 1'b0, auto_detect_on_expiry_i = 1'b0;
  logic card_detect_irq_clr_i = 1'b0, wake_go = 1'b0;
  logic [4:0] cmd_code_i = 5'h00;
  logic [9:0] fifo_level_i = 10'h000, period = 10'h35C;
  logic [7:0] nv_addr_hi_i = 8'h02;
  rcps_sample_s sample_i = '0;
  rcps_limits_s limits_i = '0;
  logic ref_tick_i, slow_osc_edge_i, wake_event_i, cmd_busy_o, cmd_go_o;
  logic cmd_abort_o, ready_o, in_standby_o, card_detect_irq_o, trim_busy_o;
  logic [4:0] active_cmd_o;
  logic [7:0] slow_oscillator_trim_o;
  logic [9:0] ref_count_o;
  rcps_power_s power_o;
  rcps_sample_s result_o;
  int errors = 0, comparisons = 0, n;

  rcps_sequencer #(.STARTUP_CYCLES(50), .PD_HOLD_CYCLES(4),
    .WAKE_CYCLES(5)) dut_u (.*);
  rcps_osc_model osc_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .period_i(period), .wake_go_i(wake_go), .ref_tick_o(ref_tick_i),
    .slow_osc_edge_o(slow_osc_edge_i), .wake_event_o(wake_event_i));

  always #2.5 core_clk_i = ~core_clk_i;

  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", s, e, g);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic cmd(input logic [4:0] c);
    @(posedge core_clk_i);
    cmd_code_i <= c;
    cmd_write_i <= 1'b1;
    @(posedge core_clk_i);
    cmd_write_i <= 1'b0;
  endtask
  task automatic wake();
    @(posedge core_clk_i);
    wake_go <= 1'b1;
    @(posedge core_clk_i);
    wake_go <= 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_cmds();
    logic [4:0] ac [12] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0C,
      5'h0D, 5'h01, 5'h04, 5'h05, 5'h1C, 5'h1F};
    int an [12] = '{1, 1, 3, 2, 3, 4, 2, 0, 0, 0, 0, 0};
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk_i);
      fifo_level_i <= 10'(an[i] > 0 ? an[i] - 1 : 0);
      cmd(ac[i]);
      #1;
      if (an[i] > 0) begin
        idle(4);
        chk("early go", 1'b0, cmd_go_o);
        @(posedge core_clk_i);
        fifo_level_i <= 10'(an[i]);
        idle(1);
      end
      if (ac[i] == 5'h1F) begin
        chk("soft reset", 1'b1, power_o.regs_reset);
      end else begin
        for (n = 1; n < 4 && cmd_go_o !== 1'b1; n++) idle(1);
        chk("go", 1'b1, cmd_go_o);
      end
      chk("code", ac[i], active_cmd_o);
      cmd(5'h00);
      #1;
      chk("cancel", ac[i] != 5'h1F, cmd_abort_o);
    end
    @(posedge core_clk_i);
    nv_addr_hi_i <= 8'h01;
    fifo_level_i <= 10'h004;
    cmd(5'h0C);
    idle(1);
    for (n = 1; n < 4 && cmd_abort_o !== 1'b1; n++) idle(1);
    chk("bad sector", 1'b1, cmd_abort_o);
  endtask

  task automatic t_power();
    @(posedge core_clk_i);
    fifo_level_i <= 10'h001;
    cmd(5'h07);
    @(posedge core_clk_i);
    modem_disable_bit_i <= 1'b1;
    idle(3);
    chk("radio", 2'b00, {power_o.tx_on, power_o.rx_on});
    @(posedge core_clk_i);
    standby_request_bit_i <= 1'b1;
    modem_disable_bit_i <= 1'b0;
    idle(1);
    chk("standby", 1'b1, in_standby_o);
    chk("kept", 5'h07, active_cmd_o);
    @(posedge core_clk_i);
    standby_request_bit_i <= 1'b0;
    for (n = 1; n < 20 && ready_o !== 1'b1; n++) idle(1);
    chk("wake time", 8, n);
    cmd(5'h07);
    idle(2);
    chk("run", 1'b1, cmd_busy_o);
    @(posedge core_clk_i);
    cmd_done_i <= 1'b1;
    @(posedge core_clk_i);
    cmd_done_i <= 1'b0;
    idle(1);
    chk("done", 1'b0, cmd_busy_o);
  endtask

  task automatic t_trim();
    @(posedge core_clk_i);
    trim_enable_i <= 1'b1;
    cmd(5'h01);
    wake();
    idle(100);
    chk("trim run", 1'b1, trim_busy_o);
    cmd(5'h00);
    idle(3);
    chk("trim cancel", 1'b0, trim_busy_o);
    cmd(5'h01);
    wake();
    idle(2000);
    chk("ref end", REF_RELOAD - period + 10'h001, ref_count_o);
    @(posedge core_clk_i);
    period <= 10'h348;
    wake();
    idle(3);
    chk("trim up", TRIM_RESET + 8'h01, slow_oscillator_trim_o);
    idle(2000);
    @(posedge core_clk_i);
    period <= REF_NOMINAL_COUNTS;
    wake();
    idle(3);
    chk("trim down", TRIM_RESET, slow_oscillator_trim_o);
    idle(2000);
    chk("ref end", REF_RELOAD - REF_NOMINAL_COUNTS + 10'h001,
      ref_count_o);
    chk("trim stop", 1'b0, trim_busy_o);
  endtask

  task automatic t_detect();
    rcps_sample_s sv [3] = '{'{8'h0F, 8'h0F}, '{8'h0F, 8'h1E},
      '{8'h05, 8'h0F}};
    logic ex [3] = '{1'b0, 1'b1, 1'b1};
    @(posedge core_clk_i);
    limits_i <= '{8'h0A, 8'h14, 8'h0A, 8'h14};
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_i);
      sample_i <= sv[i];
      card_detect_irq_clr_i <= 1'b1;
      @(posedge core_clk_i);
      card_detect_irq_clr_i <= 1'b0;
      idle(1);
      chk("irq clear", 1'b0, card_detect_irq_o);
      cmd(5'h01);
      wake();
      idle(6);
      chk("irq", ex[i], card_detect_irq_o);
      chk("sample", sv[i], result_o);
      chk("no standby", 1'b0, in_standby_o);
    end
    @(posedge core_clk_i);
    auto_wake_enable_i <= 1'b1;
    auto_rearm_enable_i <= 1'b1;
    cmd(5'h01);
    wake();
    idle(6);
    chk("rearm", 1'b1, in_standby_o);
    cmd(5'h00);
  endtask

  task automatic t_shutdown();
    @(posedge core_clk_i);
    shutdown_pin_i <= 1'b1;
    idle(2);
    chk("hold", 1'b1, ready_o);
    idle(6);
    chk("off", 3'b110, {power_o.outputs_float, power_o.inputs_clamped,
      power_o.regulators_on});
    chk("irq reset", 1'b0, card_detect_irq_o);
    @(posedge core_clk_i);
    shutdown_pin_i <= 1'b0;
    for (n = 1; n < 80 && ready_o !== 1'b1; n++) idle(1);
    chk("startup", 1'b1, n >= 51 && n <= 53);
  endtask

  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    idle(2);
    chk("ready", 1'b1, ready_o);
    chk("trim", TRIM_RESET, slow_oscillator_trim_o);
    t_cmds();
    t_power();
    t_trim();
    t_detect();
    t_shutdown();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    test_done();
  end
endmodule
